/* File: rtl/dac_ctl_pkg.sv */
package dac_ctl_pkg;

	// Register offsets
	localparam logic [7:0] OFS_MUTE       = 8'h40;
	localparam logic [7:0] OFS_GAIN       = 8'h41;
	localparam logic [7:0] OFS_RSVD       = 8'h42;
	localparam logic [7:0] OFS_HEADSET    = 8'h43;
	localparam logic [7:0] OFS_COMPRESS   = 8'h44;

	// Reset values
	localparam logic [7:0] RST_MUTE       = 8'h0C;
	localparam logic [7:0] RST_GAIN       = 8'h00;
	localparam logic [7:0] RST_RSVD       = 8'h00;
	localparam logic [7:0] RST_HEADSET    = 8'h00;
	localparam logic [7:0] RST_COMPRESS   = 8'h0F;

	// Field positions
	localparam int         MUTE_BIT       = 3;
	localparam int         HS_EN_BIT      = 7;
	localparam int         HS_STAT_LSB    = 5;
	localparam int         HS_DEB_LSB     = 2;
	localparam int         BTN_DEB_LSB    = 0;
	localparam int         COMP_EN_BIT    = 6;
	localparam int         COMP_THR_LSB   = 2;
	localparam int         COMP_HYS_LSB   = 0;

	// Detection result codes
	localparam logic [1:0] HS_NONE        = 2'h0;
	localparam logic [1:0] HS_NO_MIC      = 2'h1;
	localparam logic [1:0] HS_WITH_MIC    = 2'h3;

	// Soft-step modes
	localparam logic [1:0] STEP_EVERY     = 2'h0;
	localparam logic [1:0] STEP_EVERY2    = 2'h1;
	localparam logic [1:0] STEP_AT_ONCE   = 2'h2;

	// Debounce timing against the 1 MHz reference
	localparam int         REF_CLK_HZ     = 1000000;
	localparam int         REF_TICKS_PER_MS = REF_CLK_HZ / 1000;
	localparam int         HS_SAMPLE_MS   = 2;
	localparam int         BTN_SAMPLE_MS  = 1;
	localparam logic [2:0] HS_DEB_MAX     = 3'h5;

	// Gain arithmetic: 12 half-dB steps per 6 dB octave
	localparam int         GAIN_STEPS_OCT = 12;
	localparam logic [8:0] GAIN_BIAS      = 9'h084;
	localparam logic [3:0] GAIN_UNITY_Q   = 4'hB;

endpackage : dac_ctl_pkg

/* File: rtl/input_debounce.sv */
`timescale 1ns/1ps
module input_debounce (
	input  wire logic        clk_sys_i,  // System clock
	input  wire logic        resetn_i,   // Async reset, active low
	input  wire logic        ref_tick_i, // 1 MHz reference tick
	input  wire logic        enable_i,   // Debounce running
	input  wire logic        bypass_i,   // No debounce, follow input
	input  wire logic [16:0] interval_i, // Sample interval in ref ticks
	input  wire logic        raw_i,      // Raw level
	output logic             stable_o    // Debounced level
);

	logic [16:0] div_cnt_reg;
	logic        samp_stb_reg;
	logic [2:0]  agree_cnt_reg;
	logic        stable_reg;
	wire         div_wrap = (div_cnt_reg + 17'h00001) >= interval_i;

	assign stable_o = stable_reg;

	// Sample strobe at one eighth of the debounce time
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt_reg  <= 17'h00000;
			samp_stb_reg <= 1'b0;
		end else if (!enable_i || bypass_i) begin
			div_cnt_reg  <= 17'h00000;
			samp_stb_reg <= 1'b0;
		end else begin
			samp_stb_reg <= ref_tick_i && div_wrap;
			if (ref_tick_i)
				div_cnt_reg <= div_wrap ? 17'h00000 : div_cnt_reg + 17'h00001;
		end
	end

	// Eight consecutive differing samples make a change
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			agree_cnt_reg <= 3'h0;
			stable_reg    <= 1'b0;
		end else if (!enable_i) begin
			agree_cnt_reg <= 3'h0;
			stable_reg    <= 1'b0;
		end else if (bypass_i) begin
			agree_cnt_reg <= 3'h0;
			stable_reg    <= raw_i;
		end else if (samp_stb_reg) begin
			if (raw_i == stable_reg)
				agree_cnt_reg <= 3'h0;
			else if (agree_cnt_reg == 3'h7) begin
				agree_cnt_reg <= 3'h0;
				stable_reg    <= raw_i;
			end else
				agree_cnt_reg <= agree_cnt_reg + 3'h1;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	property p_div_on_ref;
		!ref_tick_i && enable_i && !bypass_i |=> $stable(div_cnt_reg);
	endproperty
	a_div_on_ref: assert property (p_div_on_ref) else $error("divider moved without ref tick");

	property p_change_on_sample;
		enable_i && !bypass_i && $past(enable_i) && $past(!bypass_i) && $changed(stable_reg)
			|-> $past(samp_stb_reg) && $past(agree_cnt_reg) == 3'h7;
	endproperty
	a_change_on_sample: assert property (p_change_on_sample) else $error("change off sample");

	property p_bypass_follow;
		enable_i && bypass_i |=> !$past(enable_i) || stable_o == $past(raw_i);
	endproperty
	a_bypass_follow: assert property (p_bypass_follow) else $error("bypass not followed");

endmodule : input_debounce

/* File: rtl/gain_stepper.sv */
`timescale 1ns/1ps
module gain_stepper (
	input  wire logic       clk_sys_i,    // System clock
	input  wire logic       resetn_i,     // Async reset, active low
	input  wire logic       sample_tick_i,// One pulse per sample period
	input  wire logic [1:0] step_mode_i,  // Soft-step mode
	input  wire logic [7:0] target_i,     // Requested gain code
	output logic      [7:0] current_o     // Gain code in effect
);

	logic [7:0] cur_reg;
	logic       half_reg;
	wire        at_once  = (step_mode_i != dac_ctl_pkg::STEP_EVERY) &&
	                       (step_mode_i != dac_ctl_pkg::STEP_EVERY2);
	wire        go_up    = $signed(target_i) > $signed(cur_reg);
	wire        step_ok  = (step_mode_i == dac_ctl_pkg::STEP_EVERY) || half_reg;

	assign current_o = cur_reg;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur_reg  <= dac_ctl_pkg::RST_GAIN;
			half_reg <= 1'b0;
		end else if (sample_tick_i) begin
			half_reg <= !half_reg;
			if (at_once)
				cur_reg <= target_i;
			else if (step_ok && cur_reg != target_i)
				cur_reg <= go_up ? cur_reg + 8'h01 : cur_reg - 8'h01;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	property p_one_step;
		sample_tick_i && step_mode_i == dac_ctl_pkg::STEP_EVERY && cur_reg != target_i
			|=> (cur_reg - $past(cur_reg) == 8'h01) || ($past(cur_reg) - cur_reg == 8'h01);
	endproperty
	a_one_step: assert property (p_one_step) else $error("gain did not step by one");

	property p_at_once;
		sample_tick_i && step_mode_i == dac_ctl_pkg::STEP_AT_ONCE |=> cur_reg == $past(target_i);
	endproperty
	a_at_once: assert property (p_at_once) else $error("gain not applied at once");

	property p_hold_between;
		!sample_tick_i |=> $stable(cur_reg);
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("gain moved off sample");

endmodule : gain_stepper

/* File: rtl/dac_ctl_regs.sv */
`timescale 1ns/1ps
module dac_ctl_regs #(
	parameter int REF_TICKS_PER_MS = dac_ctl_pkg::REF_TICKS_PER_MS
) (
	input  wire logic        clk_sys_i,        // System clock, 50 MHz
	input  wire logic        resetn_i,         // Async reset, active low
	input  wire logic [7:0]  reg_addr_i,       // Register address
	input  wire logic [7:0]  reg_wdata_i,      // Write data
	input  wire logic        reg_we_i,         // Write strobe
	input  wire logic        reg_re_i,         // Read strobe
	output logic      [7:0]  reg_rdata_o,      // Read data, one cycle after strobe
	input  wire logic        ref_tick_i,       // 1 MHz reference tick
	input  wire logic [1:0]  softstep_mode_i,  // Volume soft-step setting
	input  wire logic        sample_tick_i,    // Sample period pulse
	input  wire logic [15:0] sample_i,         // Input playback sample
	output logic      [15:0] sample_o,         // Output playback sample
	output logic             sample_valid_o,   // Output sample pulse
	output logic             mute_o,           // Playback muted
	output logic      [7:0]  gain_code_o,      // Gain code in effect
	input  wire logic        jack_sense_i,     // Raw headset insertion
	input  wire logic        mic_sense_i,      // Raw microphone presence
	input  wire logic        button_i,         // Raw headset button
	output logic      [1:0]  headset_status_o, // Detection result
	output logic             button_pressed_o, // Debounced button
	output logic             comp_enable_o,    // Compression enabled
	output logic      [2:0]  comp_threshold_o, // Compression threshold code
	output logic      [1:0]  comp_hysteresis_o // Compression hysteresis code
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0] mute_reg;
	logic [7:0] gain_reg;
	logic [7:0] rsvd_reg;
	logic [7:0] headset_reg;
	logic [7:0] compress_reg;
	logic [7:0] rdata_reg;

	wire hit_mute     = reg_addr_i == dac_ctl_pkg::OFS_MUTE;
	wire hit_gain     = reg_addr_i == dac_ctl_pkg::OFS_GAIN;
	wire hit_rsvd     = reg_addr_i == dac_ctl_pkg::OFS_RSVD;
	wire hit_headset  = reg_addr_i == dac_ctl_pkg::OFS_HEADSET;
	wire hit_compress = reg_addr_i == dac_ctl_pkg::OFS_COMPRESS;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mute_reg     <= dac_ctl_pkg::RST_MUTE;
			gain_reg     <= dac_ctl_pkg::RST_GAIN;
			rsvd_reg     <= dac_ctl_pkg::RST_RSVD;
			headset_reg  <= dac_ctl_pkg::RST_HEADSET;
			compress_reg <= dac_ctl_pkg::RST_COMPRESS;
		end else if (reg_we_i) begin
			if (hit_mute)
				mute_reg <= reg_wdata_i;
			if (hit_gain)
				gain_reg <= reg_wdata_i;
			if (hit_rsvd)
				rsvd_reg <= reg_wdata_i;
			if (hit_headset)
				headset_reg <= reg_wdata_i;
			if (hit_compress)
				compress_reg <= reg_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	logic [1:0] status_reg;
	wire  [7:0] headset_rd = {headset_reg[dac_ctl_pkg::HS_EN_BIT], status_reg,
	                          headset_reg[4:0]};
	wire  [7:0] rd_mux     = hit_mute     ? mute_reg     :
	                         hit_gain     ? gain_reg     :
	                         hit_rsvd     ? rsvd_reg     :
	                         hit_headset  ? headset_rd   :
	                         hit_compress ? compress_reg : 8'h00;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			rdata_reg <= 8'h00;
		else if (reg_re_i)
			rdata_reg <= rd_mux;
	end

	assign reg_rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Headset and button detection

	wire        det_en   = headset_reg[dac_ctl_pkg::HS_EN_BIT];
	wire  [2:0] hs_code  = headset_reg[dac_ctl_pkg::HS_DEB_LSB +: 3];
	wire  [1:0] btn_code = headset_reg[dac_ctl_pkg::BTN_DEB_LSB +: 2];
	wire        hs_ok    = hs_code <= dac_ctl_pkg::HS_DEB_MAX;
	wire  [1:0] btn_sh   = btn_code - 2'h1;
	wire [16:0] hs_interval  = 17'((dac_ctl_pkg::HS_SAMPLE_MS * REF_TICKS_PER_MS) << hs_code);
	wire [16:0] btn_interval = 17'((dac_ctl_pkg::BTN_SAMPLE_MS * REF_TICKS_PER_MS) << btn_sh);
	wire        jack_db;
	wire        btn_db;
	logic       btn_reg;

	input_debounce u_jack_debounce (
		.clk_sys_i  (clk_sys_i),
		.resetn_i   (resetn_i),
		.ref_tick_i (ref_tick_i),
		.enable_i   (det_en && hs_ok),
		.bypass_i   (1'b0),
		.interval_i (hs_interval),
		.raw_i      (jack_sense_i),
		.stable_o   (jack_db)
	);

	input_debounce u_button_debounce (
		.clk_sys_i  (clk_sys_i),
		.resetn_i   (resetn_i),
		.ref_tick_i (ref_tick_i),
		.enable_i   (det_en),
		.bypass_i   (btn_code == 2'h0),
		.interval_i (btn_interval),
		.raw_i      (button_i),
		.stable_o   (btn_db)
	);

	wire [1:0] status_next = !det_en ? dac_ctl_pkg::HS_NONE     :
	                         !jack_db ? dac_ctl_pkg::HS_NONE    :
	                         mic_sense_i ? dac_ctl_pkg::HS_WITH_MIC :
	                         dac_ctl_pkg::HS_NO_MIC;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_reg <= dac_ctl_pkg::HS_NONE;
			btn_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			btn_reg    <= det_en && jack_db && btn_db;
		end
	end

	assign headset_status_o = status_reg;
	assign button_pressed_o = btn_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Gain and mute on the playback path

	function automatic logic [15:0] half_db_mant(input logic [3:0] idx);
		case (idx)
			4'h0:    half_db_mant = 16'h8000;
			4'h1:    half_db_mant = 16'h879C;
			4'h2:    half_db_mant = 16'h8FAD;
			4'h3:    half_db_mant = 16'h9838;
			4'h4:    half_db_mant = 16'hA145;
			4'h5:    half_db_mant = 16'hAADC;
			4'h6:    half_db_mant = 16'hB505;
			4'h7:    half_db_mant = 16'hBFC9;
			4'h8:    half_db_mant = 16'hCB30;
			4'h9:    half_db_mant = 16'hD745;
			4'hA:    half_db_mant = 16'hE412;
			4'hB:    half_db_mant = 16'hF1A2;
			default: half_db_mant = 16'h8000;
		endcase
	endfunction : half_db_mant

	wire        [7:0]  gain_cur;

	gain_stepper u_gain_stepper (
		.clk_sys_i     (clk_sys_i),
		.resetn_i      (resetn_i),
		.sample_tick_i (sample_tick_i),
		.step_mode_i   (softstep_mode_i),
		.target_i      (gain_reg),
		.current_o     (gain_cur)
	);

	// Code plus bias splits into octave count and half-dB step within it
	wire        [8:0]  gain_biased = {gain_cur[7], gain_cur} + dac_ctl_pkg::GAIN_BIAS;
	wire        [3:0]  gain_oct    = 4'(gain_biased / 9'(dac_ctl_pkg::GAIN_STEPS_OCT));
	wire        [3:0]  gain_step   = 4'(gain_biased % 9'(dac_ctl_pkg::GAIN_STEPS_OCT));
	wire signed [16:0] mant        = $signed({1'b0, half_db_mant(gain_step)});
	wire signed [32:0] prod        = $signed(sample_i) * mant;
	wire signed [39:0] prod_ext    = 40'(prod);
	wire        [3:0]  up_sh       = gain_oct - dac_ctl_pkg::GAIN_UNITY_Q;
	wire        [4:0]  dn_sh       = 5'h1A - {1'b0, gain_oct};
	wire signed [39:0] scaled      = (gain_oct >= dac_ctl_pkg::GAIN_UNITY_Q) ?
	                                 ((prod_ext <<< up_sh) >>> 15) : (prod_ext >>> dn_sh);
	wire               sat_hi      = !scaled[39] && (scaled[38:15] != 24'h000000);
	wire               sat_lo      = scaled[39] && (scaled[38:15] != 24'hFFFFFF);
	wire        [15:0] gained      = sat_hi ? 16'h7FFF : sat_lo ? 16'h8000 : scaled[15:0];
	wire               muted       = mute_reg[dac_ctl_pkg::MUTE_BIT];

	logic [15:0] sample_reg;
	logic        valid_reg;
	logic        mute_out_reg;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sample_reg   <= 16'h0000;
			valid_reg    <= 1'b0;
			mute_out_reg <= dac_ctl_pkg::RST_MUTE[dac_ctl_pkg::MUTE_BIT];
		end else begin
			valid_reg    <= sample_tick_i;
			mute_out_reg <= muted;
			if (sample_tick_i)
				sample_reg <= muted ? 16'h0000 : gained;
		end
	end

	assign sample_o       = sample_reg;
	assign sample_valid_o = valid_reg;
	assign mute_o         = mute_out_reg;
	assign gain_code_o    = gain_cur;

	////////////////////////////////////////////////////////////////////////////////
	// Compression settings

	logic       comp_en_reg;
	logic [2:0] comp_thr_reg;
	logic [1:0] comp_hys_reg;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			comp_en_reg  <= dac_ctl_pkg::RST_COMPRESS[dac_ctl_pkg::COMP_EN_BIT];
			comp_thr_reg <= dac_ctl_pkg::RST_COMPRESS[dac_ctl_pkg::COMP_THR_LSB +: 3];
			comp_hys_reg <= dac_ctl_pkg::RST_COMPRESS[dac_ctl_pkg::COMP_HYS_LSB +: 2];
		end else begin
			comp_en_reg  <= compress_reg[dac_ctl_pkg::COMP_EN_BIT];
			comp_thr_reg <= compress_reg[dac_ctl_pkg::COMP_THR_LSB +: 3];
			comp_hys_reg <= compress_reg[dac_ctl_pkg::COMP_HYS_LSB +: 2];
		end
	end

	assign comp_enable_o     = comp_en_reg;
	assign comp_threshold_o  = comp_thr_reg;
	assign comp_hysteresis_o = comp_hys_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_mute_write(logic v);
		reg_we_i && hit_mute && reg_wdata_i[dac_ctl_pkg::MUTE_BIT] == v;
	endsequence

	property p_mute_follow;
		s_mute_write(1'b1) |=> ##1 mute_o;
	endproperty
	a_mute_follow: assert property (p_mute_follow) else $error("mute not applied");

	property p_mute_zero;
		sample_tick_i && muted |=> sample_valid_o && sample_o == 16'h0000;
	endproperty
	a_mute_zero: assert property (p_mute_zero) else $error("muted sample not zero");

	property p_gain_kept;
		!(reg_we_i && hit_gain) |=> $stable(gain_reg);
	endproperty
	a_gain_kept: assert property (p_gain_kept) else $error("gain code changed unwritten");

	property p_gain_store;
		reg_we_i && hit_gain |=> gain_reg == $past(reg_wdata_i);
	endproperty
	a_gain_store: assert property (p_gain_store) else $error("gain write lost");

	property p_unity;
		sample_tick_i && !muted && gain_cur == 8'h00 |=> sample_o == $past(sample_i);
	endproperty
	a_unity: assert property (p_unity) else $error("0 dB code changed sample");

	property p_det_off;
		!det_en |=> headset_status_o == dac_ctl_pkg::HS_NONE && !button_pressed_o;
	endproperty
	a_det_off: assert property (p_det_off) else $error("detection active while off");

	property p_no_code10;
		headset_status_o != 2'h2;
	endproperty
	a_no_code10: assert property (p_no_code10) else $error("reserved status reported");

	property p_comp_follow;
		reg_we_i && hit_compress |=> ##1 comp_enable_o == $past(reg_wdata_i[6], 2)
			&& comp_threshold_o == $past(reg_wdata_i[4:2], 2)
			&& comp_hysteresis_o == $past(reg_wdata_i[1:0], 2);
	endproperty
	a_comp_follow: assert property (p_comp_follow) else $error("compression setting lost");

endmodule : dac_ctl_regs

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
module host_model (
	input  wire logic       clk_sys_i, // System clock
	input  wire logic [7:0] rdata_i,   // Read data from the block
	output logic      [7:0] addr_o,    // Register address
	output logic      [7:0] wdata_o,   // Write data
	output logic            we_o,      // Write strobe
	output logic            re_o       // Read strobe
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		we_o = 1'b0;
		re_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Host never writes illegal values into reserved places
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == dac_ctl_pkg::OFS_MUTE)
			v = {4'h0, d[3], 3'h4};
		if (a == dac_ctl_pkg::OFS_RSVD)
			v = 8'h00;
		if (a == dac_ctl_pkg::OFS_GAIN && $signed(d) > 48)
			v = 8'h30;
		if (a == dac_ctl_pkg::OFS_COMPRESS)
			v = d & 8'h5F;
		@(posedge clk_sys_i);
		#1;
		addr_o = a;
		wdata_o = v;
		we_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		we_o = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		addr_o = a;
		re_o = 1'b1;
		@(posedge clk_sys_i);
		#1;
		re_o = 1'b0;
		d = rdata_i;
	endtask : rd
endmodule : host_model

/* File: testbench/dac_gain_headset_drc_regs_tb.sv */
`timescale 1ns/1ps
module dac_gain_headset_drc_regs_tb;
	localparam logic [7:0] A_MUTE = dac_ctl_pkg::OFS_MUTE;
	localparam logic [7:0] A_GAIN = dac_ctl_pkg::OFS_GAIN;
	localparam logic [7:0] A_HS   = dac_ctl_pkg::OFS_HEADSET;
	localparam logic [7:0] A_COMP = dac_ctl_pkg::OFS_COMPRESS;
	logic        clk_sys_i, resetn_i, ref_tick_i, sample_tick_i, jack_sense_i, mic_sense_i;
	logic        button_i, sample_valid_o, mute_o, button_pressed_o, comp_enable_o;
	logic        reg_we, reg_re;
	logic [1:0]  softstep_mode_i, headset_status_o, comp_hysteresis_o;
	logic [2:0]  comp_threshold_o;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, gain_code_o;
	logic [15:0] sample_i, sample_o;
	int          n_fail, n_checks, ref_cnt;

	dac_ctl_regs #(.REF_TICKS_PER_MS(1)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
		.reg_rdata_o(reg_rdata), .ref_tick_i(ref_tick_i), .softstep_mode_i(softstep_mode_i),
		.sample_tick_i(sample_tick_i), .sample_i(sample_i), .sample_o(sample_o),
		.sample_valid_o(sample_valid_o), .mute_o(mute_o), .gain_code_o(gain_code_o),
		.jack_sense_i(jack_sense_i), .mic_sense_i(mic_sense_i), .button_i(button_i),
		.headset_status_o(headset_status_o), .button_pressed_o(button_pressed_o),
		.comp_enable_o(comp_enable_o), .comp_threshold_o(comp_threshold_o),
		.comp_hysteresis_o(comp_hysteresis_o));
	host_model host (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata), .addr_o(reg_addr),
		.wdata_o(reg_wdata), .we_o(reg_we), .re_o(reg_re));

	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// Reference tick every fourth system clock
	always @(posedge clk_sys_i) begin
		#1;
		ref_cnt = (ref_cnt + 1) % 4;
		ref_tick_i = (ref_cnt == 0);
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk("reg_rdata_o", {8'h00, d}, {8'h00, exp});
	endtask : rchk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	task automatic tick(input logic [15:0] s);
		@(posedge clk_sys_i);
		#1;
		sample_tick_i = 1'b1;
		sample_i = s;
		@(posedge clk_sys_i);
		#1;
		sample_tick_i = 1'b0;
	endtask : tick
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic wait_hs(input logic [1:0] e, input int lim);
		int k;
		k = 0;
		while (headset_status_o !== e && k < lim) begin
			cyc(1);
			k++;
		end
		if (headset_status_o !== e) begin
			chk("headset_status_o", {14'h0, headset_status_o}, {14'h0, e});
			conclude();
		end
	endtask : wait_hs
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("mute_o", {15'h0, mute_o}, 16'h1);
		chk("comp_enable_o", {15'h0, comp_enable_o}, 16'h0);
		chk("comp_threshold_o", {13'h0, comp_threshold_o}, 16'h3);
		chk("comp_hysteresis_o", {14'h0, comp_hysteresis_o}, 16'h3);
		rchk(A_MUTE, dac_ctl_pkg::RST_MUTE);
		rchk(A_GAIN, dac_ctl_pkg::RST_GAIN);
		rchk(dac_ctl_pkg::OFS_RSVD, dac_ctl_pkg::RST_RSVD);
		rchk(A_HS, dac_ctl_pkg::RST_HEADSET);
		rchk(A_COMP, dac_ctl_pkg::RST_COMPRESS);
		rchk(8'h45, 8'h00);
	endtask : t_reset
	task automatic t_comp();
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = {1'b0, i[0], 1'b0, i[2:0], i[1:0]};
			host.wr(A_COMP, v);
			cyc(2);
			chk("comp_enable_o", {15'h0, comp_enable_o}, {15'h0, v[6]});
			chk("comp_threshold_o", {13'h0, comp_threshold_o}, {13'h0, v[4:2]});
			chk("comp_hysteresis_o", {14'h0, comp_hysteresis_o}, {14'h0, v[1:0]});
			rchk(A_COMP, v);
		end
	endtask : t_comp
	task automatic t_audio();
		softstep_mode_i = 2'h2;
		host.wr(A_MUTE, 8'h00);
		cyc(2);
		chk("mute_o", {15'h0, mute_o}, 16'h0);
		host.wr(A_GAIN, 8'h0C);
		tick(16'h0000);
		chk("gain_code_o", {8'h00, gain_code_o}, 16'h000C);
		tick(16'h1000);
		chk("sample_valid_o", {15'h0, sample_valid_o}, 16'h1);
		chk("sample_o", sample_o, 16'h2000);
		cyc(1);
		chk("sample_valid_o", {15'h0, sample_valid_o}, 16'h0);
		host.wr(A_GAIN, 8'hF4);
		tick(16'h0000);
		tick(16'h1000);
		chk("sample_o", sample_o, 16'h0800);
		rchk(A_GAIN, 8'hF4);
		host.wr(A_MUTE, 8'h08);
		cyc(2);
		chk("mute_o", {15'h0, mute_o}, 16'h1);
		tick(16'h1000);
		chk("sample_o", sample_o, 16'h0000);
		chk("gain_code_o", {8'h00, gain_code_o}, 16'h00F4);
		host.wr(A_MUTE, 8'h00);
		cyc(2);
		tick(16'h1000);
		chk("sample_o", sample_o, 16'h0800);
	endtask : t_audio
	task automatic t_step();
		host.wr(A_GAIN, 8'h00);
		tick(16'h0000);
		softstep_mode_i = 2'h0;
		host.wr(A_GAIN, 8'h03);
		tick(16'h0000);
		chk("gain_code_o", {8'h00, gain_code_o}, 16'h0001);
		tick(16'h0000);
		chk("gain_code_o", {8'h00, gain_code_o}, 16'h0002);
		softstep_mode_i = 2'h1;
		host.wr(A_GAIN, 8'h00);
		tick(16'h0000);
		tick(16'h0000);
		chk("gain_code_o", {8'h00, gain_code_o}, 16'h0001);
		tick(16'h0000);
		tick(16'h0000);
		chk("gain_code_o", {8'h00, gain_code_o}, 16'h0000);
	endtask : t_step
	task automatic t_headset();
		jack_sense_i = 1'b1;
		mic_sense_i = 1'b1;
		button_i = 1'b1;
		cyc(40);
		chk("headset_status_o", {14'h0, headset_status_o}, 16'h0);
		host.wr(A_HS, 8'h80);
		cyc(46);
		chk("headset_status_o", {14'h0, headset_status_o}, 16'h0);
		wait_hs(2'h3, 100);
		chk("button_pressed_o", {15'h0, button_pressed_o}, 16'h1);
		rchk(A_HS, 8'hE0);
		mic_sense_i = 1'b0;
		cyc(2);
		chk("headset_status_o", {14'h0, headset_status_o}, 16'h1);
		button_i = 1'b0;
		cyc(2);
		chk("button_pressed_o", {15'h0, button_pressed_o}, 16'h0);
		// Button code 01: eight samples one reference tick apart
		host.wr(A_HS, 8'h81);
		button_i = 1'b1;
		cyc(24);
		chk("button_pressed_o", {15'h0, button_pressed_o}, 16'h0);
		cyc(16);
		chk("button_pressed_o", {15'h0, button_pressed_o}, 16'h1);
		host.wr(A_HS, 8'h00);
		cyc(2);
		chk("headset_status_o", {14'h0, headset_status_o}, 16'h0);
		host.wr(A_HS, 8'h98);
		cyc(5000);
		chk("headset_status_o", {14'h0, headset_status_o}, 16'h0);
	endtask : t_headset
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		n_checks = 0;
		ref_cnt = 0;
		resetn_i = 1'b0;
		ref_tick_i = 1'b0;
		sample_tick_i = 1'b0;
		sample_i = 16'h0000;
		softstep_mode_i = 2'h0;
		jack_sense_i = 1'b0;
		mic_sense_i = 1'b0;
		button_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		resetn_i = 1'b1;
		t_reset();
		t_comp();
		t_audio();
		t_step();
		t_headset();
		conclude();
	end
endmodule : dac_gain_headset_drc_regs_tb
